// ===== src/smbus_rd_pkg.sv
// Shared constants and types for the two ends of the register read port.
package smbus_rd_pkg;

	// Link timing: the host end divides its clock down to this bus period.
	localparam int CLK_PERIOD_NS  = 20;
	localparam int SCL_PERIOD_NS  = 320;
	localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

	// Register space seen over the link.
	localparam int REG_COUNT = 7;
	localparam int REG_WIDTH = 16;
	localparam int SEL_WIDTH = 8;

	// Bit positions within one nine-clock byte slot.
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;
	localparam logic [3:0] ACK_SLOT      = 4'h8;

	// Slave address; the value is arbitrary.
	localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2C;
	localparam logic       RW_WRITE           = 1'b0;
	localparam logic       RW_READ            = 1'b1;

	// Reset values.
	localparam logic [7:0]  SEL_RESET  = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0]  BYTE_RESET = 8'h00;

	// Host sequence steps, in bus order.
	localparam logic [3:0] STEP_START_SEL = 4'h0;
	localparam logic [3:0] STEP_CTRL_WR   = 4'h1;
	localparam logic [3:0] STEP_REG_ADDR  = 4'h2;
	localparam logic [3:0] STEP_STOP_SEL  = 4'h3;
	localparam logic [3:0] STEP_START_RD  = 4'h4;
	localparam logic [3:0] STEP_CTRL_RD   = 4'h5;
	localparam logic [3:0] STEP_RX_LO     = 4'h6;
	localparam logic [3:0] STEP_RX_HI     = 4'h7;
	localparam logic [3:0] STEP_STOP_RD   = 4'h8;

	typedef enum logic [3:0] {
		KIND_START = 4'h1,
		KIND_STOP  = 4'h2,
		KIND_TX    = 4'h4,
		KIND_RX    = 4'h8
	} slot_kind_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'h1,
		H_RUN  = 3'h2,
		H_HOLD = 3'h4
	} host_state_t;

	typedef enum logic [6:0] {
		D_CTRL     = 7'h01,
		D_CTRL_ACK = 7'h02,
		D_ADDR     = 7'h04,
		D_ADDR_ACK = 7'h08,
		D_TX       = 7'h10,
		D_TX_ACK   = 7'h20,
		D_IGNORE   = 7'h40
	} dev_state_t;

endpackage : smbus_rd_pkg

// ===== src/smbus_link_if.sv
// Two-wire link between the host end and the device end.
`timescale 1ns/1ps
interface smbus_link_if;
	logic scl;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic sda;

	// Open-drain data line with a pull-up: low while any end drives low.
	assign sda = ~((host_sda_oe & ~host_sda_out) |
		(dev_sda_oe & ~dev_sda_out));

	modport host (output scl, host_sda_out, host_sda_oe, input sda);
	modport dev (input scl, sda, output dev_sda_out, dev_sda_oe);
endinterface : smbus_link_if

// ===== src/smbus_sync.sv
// Two-flop synchroniser for signals entering the system clock domain.
`timescale 1ns/1ps
module smbus_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,  // Destination clock.
	input  wire logic             nrst_in, // Async reset, active low.
	input  wire logic             ce_in,   // Clock enable.
	input  wire logic [WIDTH-1:0] d_in,    // Asynchronous input.
	output logic      [WIDTH-1:0] q_out    // Synchronised output.
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] out_d;

	always_comb begin
		meta_d = ce_in ? d_in : meta_q;
		out_d  = ce_in ? meta_q : q_out;
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= meta_d;
			q_out  <= out_d;
		end
	end
endmodule : smbus_sync

// ===== src/smbus_dev_end.sv
// Device end: register read port, link logic clocked by the bus clock.
`timescale 1ns/1ps
module smbus_dev_end #(
	parameter logic [6:0] OWN_ADDR  = smbus_rd_pkg::SLAVE_ADDR_DEFAULT,
	parameter int         REG_COUNT = smbus_rd_pkg::REG_COUNT
) (
	input  wire logic                   clk_sys_in,  // System clock.
	input  wire logic                   nrst_in,     // Async reset, low.
	input  wire logic                   ce_in,       // Clock enable.
	smbus_link_if.dev                   link,        // Bus wires.
	input  wire logic [REG_COUNT*16-1:0] reg_words_in, // Register words.
	output logic      [7:0]             reg_sel_out, // Selected address.
	output logic                        frame_active_out // Inside a frame.
);

	smbus_rd_pkg::dev_state_t state_q;
	smbus_rd_pkg::dev_state_t state_d;
	logic [2:0]  bit_q;
	logic [2:0]  bit_d;
	logic [7:0]  shift_q;
	logic [7:0]  shift_d;
	logic        rw_q;
	logic        rw_d;
	logic        hi_q;
	logic        hi_d;
	logic [7:0]  sel_q;
	logic [7:0]  sel_d;
	logic        oe_q;
	logic        oe_d;
	logic [7:0]  tx_byte;
	logic        link_rst_n;
	logic        scl_s;
	logic        sda_s;
	logic [7:0]  sel_s;
	logic        sda_prev_q;
	logic        frame_rst_q;
	logic        frame_rst_d;
	logic        active_q;
	logic        active_d;
	logic [15:0] word_q;
	logic [15:0] word_d;
	logic [15:0] picked;
	logic        start_seen;
	logic        stop_seen;

	// Start or Stop restarts the byte engine; the selection survives.
	assign link_rst_n = nrst_in & ~frame_rst_q;

	// Byte engine, sampling the data line on the rising bus clock.
	always_comb begin
		state_d = state_q;
		bit_d   = bit_q;
		shift_d = shift_q;
		rw_d    = rw_q;
		hi_d    = hi_q;
		sel_d   = sel_q;
		case (state_q)
			smbus_rd_pkg::D_CTRL: begin
				shift_d = {shift_q[6:0], link.sda};
				bit_d   = bit_q + 3'h1;
				if (bit_q == smbus_rd_pkg::LAST_DATA_BIT) begin
					if (shift_q[6:0] == OWN_ADDR) begin
						state_d = smbus_rd_pkg::D_CTRL_ACK;
						rw_d    = link.sda;
					end else begin
						state_d = smbus_rd_pkg::D_IGNORE;
					end
				end
			end
			smbus_rd_pkg::D_CTRL_ACK: begin
				hi_d = 1'b0;
				if (rw_q == smbus_rd_pkg::RW_READ) begin
					state_d = smbus_rd_pkg::D_TX;
				end else begin
					state_d = smbus_rd_pkg::D_ADDR;
				end
			end
			smbus_rd_pkg::D_ADDR: begin
				shift_d = {shift_q[6:0], link.sda};
				bit_d   = bit_q + 3'h1;
				if (bit_q == smbus_rd_pkg::LAST_DATA_BIT) begin
					state_d = smbus_rd_pkg::D_ADDR_ACK;
					sel_d   = {shift_q[6:0], link.sda};
				end
			end
			smbus_rd_pkg::D_ADDR_ACK: begin
				// Data bytes of a write are not taken by this port.
				state_d = smbus_rd_pkg::D_IGNORE;
			end
			smbus_rd_pkg::D_TX: begin
				bit_d = bit_q + 3'h1;
				if (bit_q == smbus_rd_pkg::LAST_DATA_BIT) begin
					state_d = smbus_rd_pkg::D_TX_ACK;
				end
			end
			smbus_rd_pkg::D_TX_ACK: begin
				if (!link.sda && !hi_q) begin
					state_d = smbus_rd_pkg::D_TX;
					hi_d    = 1'b1;
				end else begin
					state_d = smbus_rd_pkg::D_IGNORE;
				end
			end
			smbus_rd_pkg::D_IGNORE: begin
				state_d = smbus_rd_pkg::D_IGNORE;
			end
			default: begin
				state_d = smbus_rd_pkg::D_IGNORE;
			end
		endcase
	end

	always_ff @(posedge link.scl or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_q <= smbus_rd_pkg::D_CTRL;
			bit_q   <= 3'h0;
			shift_q <= smbus_rd_pkg::BYTE_RESET;
			rw_q    <= smbus_rd_pkg::RW_WRITE;
			hi_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q   <= bit_d;
			shift_q <= shift_d;
			rw_q    <= rw_d;
			hi_q    <= hi_d;
		end
	end

	always_ff @(posedge link.scl or negedge nrst_in) begin
		if (!nrst_in) begin
			sel_q <= smbus_rd_pkg::SEL_RESET;
		end else begin
			sel_q <= sel_d;
		end
	end

	// Line driver, changing the data line on the falling bus clock.
	always_comb begin
		tx_byte = hi_q ? word_q[15:8] : word_q[7:0];
		case (state_q)
			smbus_rd_pkg::D_CTRL_ACK: oe_d = 1'b1;
			smbus_rd_pkg::D_ADDR_ACK: oe_d = 1'b1;
			smbus_rd_pkg::D_TX:       oe_d = ~tx_byte[~bit_q];
			default:                  oe_d = 1'b0;
		endcase
	end

	always_ff @(negedge link.scl or negedge link_rst_n) begin
		if (!link_rst_n) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= oe_d;
		end
	end

	assign link.dev_sda_out = 1'b0;
	assign link.dev_sda_oe  = oe_q;

	// System side: watch the wires for Start and Stop.
	smbus_sync #(.WIDTH(2)) u_pin_sync (
		.clk_in  (clk_sys_in),
		.nrst_in (nrst_in),
		.ce_in   (ce_in),
		.d_in    ({link.scl, link.sda}),
		.q_out   ({scl_s, sda_s})
	);

	smbus_sync #(.WIDTH(8)) u_sel_sync (
		.clk_in  (clk_sys_in),
		.nrst_in (nrst_in),
		.ce_in   (ce_in),
		.d_in    (sel_q),
		.q_out   (sel_s)
	);

	// The word is snapshotted at Start and stays still for the frame.
	always_comb begin
		picked = smbus_rd_pkg::WORD_RESET;
		for (int i = 0; i < REG_COUNT; i++) begin
			if (sel_s == 8'(i)) begin
				picked = reg_words_in[i*16 +: 16];
			end
		end
		start_seen  = scl_s & sda_prev_q & ~sda_s;
		stop_seen   = scl_s & ~sda_prev_q & sda_s;
		frame_rst_d = start_seen | stop_seen;
		active_d    = start_seen | (active_q & ~stop_seen);
		word_d      = start_seen ? picked : word_q;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sda_prev_q  <= 1'b0;
			frame_rst_q <= 1'b0;
			active_q    <= 1'b0;
			word_q      <= smbus_rd_pkg::WORD_RESET;
		end else if (ce_in) begin
			sda_prev_q  <= sda_s;
			frame_rst_q <= frame_rst_d;
			active_q    <= active_d;
			word_q      <= word_d;
		end
	end

	assign reg_sel_out      = sel_s;
	assign frame_active_out = active_q;
endmodule : smbus_dev_end

// ===== src/smbus_host_end.sv
// Host end: runs the select-then-read sequence for one register word.
`timescale 1ns/1ps
module smbus_host_end #(
	parameter logic [6:0] TARGET_ADDR = smbus_rd_pkg::SLAVE_ADDR_DEFAULT,
	parameter int         QUARTER     = smbus_rd_pkg::QUARTER_CYCLES
) (
	input  wire logic        clk_sys_in,  // System clock.
	input  wire logic        nrst_in,     // Async reset, active low.
	input  wire logic        ce_in,       // Clock enable.
	smbus_link_if.host       link,        // Bus wires.
	input  wire logic        start_in,    // Begin a register read.
	input  wire logic [7:0]  reg_addr_in, // Register address byte.
	output logic             busy_out,    // Sequence running.
	output logic             done_out,    // Sequence over, one cycle.
	output logic             nack_out,    // A byte was refused.
	output logic      [15:0] rdata_out    // Word read back.
);
	localparam int DW = $clog2(QUARTER + 1);
	localparam logic [DW-1:0] RELOAD = DW'(QUARTER - 1);

	smbus_rd_pkg::host_state_t state_q;
	smbus_rd_pkg::host_state_t state_d;
	smbus_rd_pkg::slot_kind_t  kind;
	smbus_rd_pkg::slot_kind_t  next_kind;
	logic [3:0]    step_q;
	logic [3:0]    step_d;
	logic [3:0]    next_step;
	logic [1:0]    q_q;
	logic [1:0]    q_d;
	logic [DW-1:0] div_q;
	logic [DW-1:0] div_d;
	logic [3:0]    bit_q;
	logic [3:0]    bit_d;
	logic          scl_q;
	logic          scl_d;
	logic          low_q;
	logic          low_d;
	logic [7:0]    rxb_q;
	logic [7:0]    rxb_d;
	logic [15:0]   rdata_q;
	logic [15:0]   rdata_d;
	logic          err_q;
	logic          err_d;
	logic          done_q;
	logic          done_d;
	logic [7:0]    addr_q;
	logic [7:0]    addr_d;
	logic [7:0]    tx_byte;
	logic          tick;
	logic          nack_now;
	logic          last_bit;
	logic          sda_s;

	// Kind of bus slot that a sequence step produces.
	function automatic smbus_rd_pkg::slot_kind_t kind_of(
		input logic [3:0] step
	);
		case (step)
			smbus_rd_pkg::STEP_START_SEL: kind_of = smbus_rd_pkg::KIND_START;
			smbus_rd_pkg::STEP_START_RD:  kind_of = smbus_rd_pkg::KIND_START;
			smbus_rd_pkg::STEP_STOP_SEL:  kind_of = smbus_rd_pkg::KIND_STOP;
			smbus_rd_pkg::STEP_STOP_RD:   kind_of = smbus_rd_pkg::KIND_STOP;
			smbus_rd_pkg::STEP_RX_LO:     kind_of = smbus_rd_pkg::KIND_RX;
			smbus_rd_pkg::STEP_RX_HI:     kind_of = smbus_rd_pkg::KIND_RX;
			default:                      kind_of = smbus_rd_pkg::KIND_TX;
		endcase
	endfunction : kind_of

	smbus_sync #(.WIDTH(1)) u_sda_sync (
		.clk_in  (clk_sys_in),
		.nrst_in (nrst_in),
		.ce_in   (ce_in),
		.d_in    (link.sda),
		.q_out   (sda_s)
	);

	// Byte sent in each transmit step.
	always_comb begin
		case (step_q)
			smbus_rd_pkg::STEP_CTRL_WR:
				tx_byte = {TARGET_ADDR, smbus_rd_pkg::RW_WRITE};
			smbus_rd_pkg::STEP_CTRL_RD:
				tx_byte = {TARGET_ADDR, smbus_rd_pkg::RW_READ};
			default:
				tx_byte = addr_q;
		endcase
	end

	// Each slot is four quarters: low, data change, high, high and sample.
	always_comb begin
		state_d   = state_q;
		step_d    = step_q;
		q_d       = q_q;
		div_d     = div_q;
		bit_d     = bit_q;
		scl_d     = scl_q;
		low_d     = low_q;
		rxb_d     = rxb_q;
		rdata_d   = rdata_q;
		err_d     = err_q;
		addr_d    = addr_q;
		done_d    = 1'b0;
		kind      = kind_of(step_q);
		tick      = (div_q == '0);
		last_bit  = (bit_q == smbus_rd_pkg::ACK_SLOT);
		nack_now  = (kind == smbus_rd_pkg::KIND_TX) && last_bit && sda_s;
		next_step = step_q + 4'h1;
		if (nack_now) begin
			next_step = smbus_rd_pkg::STEP_STOP_RD;
		end
		next_kind = kind_of(next_step);
		case (state_q)
			smbus_rd_pkg::H_IDLE: begin
				scl_d = 1'b1;
				low_d = 1'b0;
				if (start_in) begin
					state_d = smbus_rd_pkg::H_RUN;
					step_d  = smbus_rd_pkg::STEP_START_SEL;
					q_d     = 2'h0;
					div_d   = RELOAD;
					bit_d   = 4'h0;
					err_d   = 1'b0;
					addr_d  = reg_addr_in;
				end
			end
			smbus_rd_pkg::H_RUN: begin
				div_d = tick ? RELOAD : div_q - 1'b1;
				if (tick) begin
					q_d = q_q + 2'h1;
					case (q_q)
						2'h0: begin
							if (kind == smbus_rd_pkg::KIND_STOP) begin
								low_d = 1'b1;
							end else if (kind == smbus_rd_pkg::KIND_TX) begin
								low_d = !last_bit && !tx_byte[~bit_q[2:0]];
							end else if (kind == smbus_rd_pkg::KIND_RX) begin
								low_d = last_bit &&
									(step_q == smbus_rd_pkg::STEP_RX_LO);
							end
						end
						2'h1: begin
							if (kind == smbus_rd_pkg::KIND_START) begin
								low_d = 1'b1;
							end else begin
								scl_d = 1'b1;
							end
						end
						2'h2: begin
							if (kind == smbus_rd_pkg::KIND_STOP) begin
								low_d = 1'b0;
							end
						end
						default: begin
							if (nack_now) begin
								err_d = 1'b1;
							end
							if (kind == smbus_rd_pkg::KIND_RX && !last_bit) begin
								rxb_d = {rxb_q[6:0], sda_s};
							end
							if (kind == smbus_rd_pkg::KIND_RX && last_bit) begin
								if (step_q == smbus_rd_pkg::STEP_RX_LO) begin
									rdata_d[7:0] = rxb_q;
								end else begin
									rdata_d[15:8] = rxb_q;
								end
							end
							if ((kind == smbus_rd_pkg::KIND_TX ||
								kind == smbus_rd_pkg::KIND_RX) && !last_bit) begin
								// The bus clock must fall between bits of a byte.
								bit_d = bit_q + 4'h1;
								scl_d = 1'b0;
							end else begin
								bit_d = 4'h0;
								if (step_q == smbus_rd_pkg::STEP_STOP_RD) begin
									state_d = smbus_rd_pkg::H_HOLD;
									done_d  = 1'b1;
								end else begin
									step_d = next_step;
									scl_d  = (next_kind == smbus_rd_pkg::KIND_START);
								end
							end
						end
					endcase
				end
			end
			smbus_rd_pkg::H_HOLD: begin
				// One idle cycle keeps two sequences from touching.
				state_d = smbus_rd_pkg::H_IDLE;
			end
			default: begin
				state_d = smbus_rd_pkg::H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_q <= smbus_rd_pkg::H_IDLE;
			step_q  <= smbus_rd_pkg::STEP_START_SEL;
			q_q     <= 2'h0;
			div_q   <= '0;
			bit_q   <= 4'h0;
			scl_q   <= 1'b1;
			low_q   <= 1'b0;
			rxb_q   <= smbus_rd_pkg::BYTE_RESET;
			rdata_q <= smbus_rd_pkg::WORD_RESET;
			err_q   <= 1'b0;
			done_q  <= 1'b0;
			addr_q  <= smbus_rd_pkg::SEL_RESET;
		end else if (ce_in) begin
			state_q <= state_d;
			step_q  <= step_d;
			q_q     <= q_d;
			div_q   <= div_d;
			bit_q   <= bit_d;
			scl_q   <= scl_d;
			low_q   <= low_d;
			rxb_q   <= rxb_d;
			rdata_q <= rdata_d;
			err_q   <= err_d;
			done_q  <= done_d;
			addr_q  <= addr_d;
		end
	end

	assign link.scl          = scl_q;
	assign link.host_sda_out = 1'b0;
	assign link.host_sda_oe  = low_q;

	assign busy_out  = (state_q != smbus_rd_pkg::H_IDLE);
	assign done_out  = done_q;
	assign nack_out  = err_q;
	assign rdata_out = rdata_q;
endmodule : smbus_host_end

// ===== verification/smbus_rd_props.sv
// Wire-level checks on the link that joins the host end to the device end.
`timescale 1ns/1ps
module smbus_rd_props (
	input wire logic clk_sys_in,   // System clock.
	input wire logic nrst_in,      // Reset, active low.
	input wire logic scl,          // Bus clock.
	input wire logic host_sda_out, // Host data value.
	input wire logic host_sda_oe,  // Host pulls data low.
	input wire logic dev_sda_out,  // Device data value.
	input wire logic dev_sda_oe,   // Device pulls data low.
	input wire logic sda           // Resolved data line.
);
	logic       scl_p_q, scl_p_d, sda_p_q, sda_p_d;
	logic       rw_q, rw_d, last_rw_q, last_rw_d, in_q, in_d;
	logic [4:0] cnt_q, cnt_d;
	logic       rise, start, stop;

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	// Counts bus clock rises since the last Start and keeps the direction.
	always_comb begin
		rise = scl & ~scl_p_q;
		start = scl & scl_p_q & sda_p_q & ~sda;
		stop = scl & scl_p_q & ~sda_p_q & sda;
		scl_p_d = scl;
		sda_p_d = sda;
		cnt_d = start ? 5'h00 : (rise ? cnt_q + 5'h01 : cnt_q);
		rw_d = (rise && cnt_q == 5'h07) ? sda : rw_q;
		last_rw_d = stop ? rw_q : last_rw_q;
		in_d = start | (in_q & ~stop);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			cnt_q <= 5'h00;
			rw_q <= 1'b0;
			last_rw_q <= 1'b1;
			in_q <= 1'b0;
		end else begin
			scl_p_q <= scl_p_d;
			sda_p_q <= sda_p_d;
			cnt_q <= cnt_d;
			rw_q <= rw_d;
			last_rw_q <= last_rw_d;
			in_q <= in_d;
		end
	end

	AST_CTRL_ACK: assert property (
		rise && cnt_q == 5'h08 |-> !sda && dev_sda_oe)
		else $error("control byte not acknowledged");
	AST_ADDR_ACK: assert property (
		rise && cnt_q == 5'h11 && !rw_q |-> dev_sda_oe && !sda)
		else $error("address byte not acknowledged");
	AST_LO_MASTER_ACK: assert property (
		rise && cnt_q == 5'h11 && rw_q |-> host_sda_oe && !dev_sda_oe)
		else $error("low byte ack not from host");
	AST_HI_NOACK: assert property (
		rise && cnt_q == 5'h1A |-> sda)
		else $error("high byte was acknowledged");
	AST_FRAME_LEN: assert property (
		stop |-> cnt_q == (rw_q ? 5'h1C : 5'h13))
		else $error("frame ended after wrong clock count");
	AST_RW_ORDER: assert property (
		rise && cnt_q == 5'h07 |-> sda != last_rw_q)
		else $error("select and read frames out of order");
	AST_DEV_EDGE: assert property (
		$changed(dev_sda_oe) |-> !scl)
		else $error("device changed data while clock high");
	AST_DEV_SILENT_CTRL: assert property (
		dev_sda_oe |-> cnt_q >= 5'h08)
		else $error("device drove during control byte");
	AST_IDLE_HIGH: assert property (
		!in_q |-> scl && !dev_sda_oe)
		else $error("bus clock low or device driving outside a frame");

	cover property (stop && rw_q);
	cover property (stop && !rw_q);
	cover property (rise && cnt_q == 5'h1A);
endmodule : smbus_rd_props

// ===== verification/smbus_register_read_port_tb.sv
// Bench: a matched host/device pair and a misaddressed pair.
`timescale 1ns/1ps
module smbus_register_read_port_tb;
	logic         clk_sys_in;
	logic         nrst_in;
	logic         ce;
	logic         start_a, start_b;
	logic [7:0]   addr;
	logic [111:0] words;
	logic         done_a, nack_a, done_b, nack_b;
	logic         busy_a, busy_b, act_a, act_b;
	logic [15:0]  rdata_a;
	logic [7:0]   sel_a, sel_b;
	logic [24:0]  q[$];
	logic [24:0]  exp_v, seen_v;
	int           error_cnt, check_count, seed_v;

	smbus_link_if link_a();
	smbus_link_if link_b();

	smbus_host_end i_smbus_host_end (.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in), .ce_in(ce), .link(link_a), .start_in(start_a),
		.reg_addr_in(addr), .busy_out(busy_a), .done_out(done_a),
		.nack_out(nack_a), .rdata_out(rdata_a));
	smbus_dev_end i_smbus_dev_end (.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in), .ce_in(ce), .link(link_a), .reg_words_in(words),
		.reg_sel_out(sel_a), .frame_active_out(act_a));
	// This host calls an address the device does not own.
	smbus_host_end #(.TARGET_ADDR(7'h2D)) i_smbus_host_end_b (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce),
		.link(link_b), .start_in(start_b), .reg_addr_in(addr),
		.busy_out(busy_b), .done_out(done_b), .nack_out(nack_b),
		.rdata_out());
	smbus_dev_end i_smbus_dev_end_b (.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in), .ce_in(ce), .link(link_b), .reg_words_in(words),
		.reg_sel_out(sel_b), .frame_active_out(act_b));
	smbus_rd_props i_smbus_rd_props (.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in), .scl(link_a.scl),
		.host_sda_out(link_a.host_sda_out), .host_sda_oe(link_a.host_sda_oe),
		.dev_sda_out(link_a.dev_sda_out), .dev_sda_oe(link_a.dev_sda_oe),
		.sda(link_a.sda));

	task automatic chk(input logic [24:0] seen, input logic [24:0] want);
		check_count++;
		if (seen !== want) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	// One select-then-read sequence with fresh random register words.
	task automatic rd(input logic alt, input logic [7:0] a);
		logic [127:0] r;
		logic [15:0]  w;
		int           n;
		r = {$urandom(), $urandom(), $urandom(), $urandom()};
		n = a;
		w = (a < 8'(smbus_rd_pkg::REG_COUNT)) ? r[n*16 +: 16] : 16'h0000;
		q.push_back(alt ? {1'b1, 8'h00, 16'h0000} : {1'b0, a, w});
		@(posedge clk_sys_in);
		words <= r[111:0];
		addr <= a;
		start_a <= ~alt;
		start_b <= alt;
		@(posedge clk_sys_in);
		start_a <= 1'b0;
		start_b <= 1'b0;
		@(posedge clk_sys_in);
		chk(25'(alt ? busy_b : busy_a), 25'h1);
		n = 0;
		while (done_a !== 1'b1 && done_b !== 1'b1 && n < 1000) begin
			@(posedge clk_sys_in);
			n++;
		end
		if (n >= 1000) begin
			error_cnt++;
		end
		repeat (2) @(posedge clk_sys_in);
		chk(25'({busy_a, busy_b, act_a, act_b}), 25'h0);
	endtask : rd

	always @(posedge clk_sys_in) begin
		if (done_a === 1'b1 || done_b === 1'b1) begin
			seen_v = (done_b === 1'b1) ? {nack_b, sel_b, 16'h0000}
				: {nack_a, sel_a, rdata_a};
			exp_v = q.pop_front();
			chk(seen_v, exp_v);
		end
	end

	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	initial begin
		nrst_in = 1'b0;
		ce = 1'b1;
		start_a = 1'b0;
		start_b = 1'b0;
		addr = 8'h00;
		words = '0;
		error_cnt = 0;
		check_count = 0;
		seed_v = $urandom(94496);
		repeat (5) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rd(1'b1, 8'h03);
		for (int i = 0; i < 7; i++) begin
			rd(1'b0, 8'(i));
		end
		// A clock-enable pause in mid-select must only delay the read.
		fork
			rd(1'b0, 8'h02);
			begin
				repeat (200) @(posedge clk_sys_in);
				ce <= 1'b0;
				repeat (40) @(posedge clk_sys_in);
				ce <= 1'b1;
			end
		join
		rd(1'b0, 8'h07);
		rd(1'b0, 8'hFF);
		// Same register twice: each read must show the words of its own frame.
		rd(1'b0, 8'h04);
		rd(1'b0, 8'h04);
		repeat (4) @(posedge clk_sys_in);
		chk(25'(q.size()), 25'h0);
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge clk_sys_in);
		error_cnt++;
		end_of_test();
	end
endmodule : smbus_register_read_port_tb
